// ---- plm_pkg.sv ----
/*
 * Shared constants of the PCM level meter: register addresses, field
 * positions, reset values and command layout.
 * Assumes a byte-wide command port whose top bit selects write (1) or
 * read (0) and whose low seven bits give the register address.
 */
`default_nettype none

package plm_pkg;

    // ------------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------------
    localparam int          CMD_WR_BIT   = 7;
    localparam int          ADDR_W       = 7;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0]  ADDR_CNT_LO  = 7'h2E;
    localparam logic [6:0]  ADDR_CTL     = 7'h2F;
    localparam logic [6:0]  ADDR_RES_LO  = 7'h30;
    localparam logic [6:0]  ADDR_RES_HI  = 7'h31;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int          CTL_ONCE_BIT = 7;
    localparam int          CTL_EN_BIT   = 6;
    localparam int          CTL_CS_LSB   = 4;
    localparam int          CTL_CS_W     = 2;
    localparam int          CTL_RSVD_BIT = 3;
    localparam int          CTL_CNT_MSB  = 2;
    localparam int          CNT_W        = 11;
    localparam int          CNT_LO_W     = 8;

    // ------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_CNT_LO   = 8'h00;
    localparam logic [7:0]  RST_CTL      = 8'h00;
    localparam logic [15:0] RST_RESULT   = 16'h0000;
    localparam logic [10:0] WINDOW_MAX   = 11'h7FF;
    localparam logic [10:0] WINDOW_NONE  = 11'h000;

    // ------------------------------------------------------------------
    // timing: one window step is one pcm frame
    // ------------------------------------------------------------------
    localparam int          FRAME_PERIOD_NS = 125000;
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        PLM_IDLE,
        PLM_MEASURE
    } plm_state_t;

endpackage

`default_nettype wire

// ---- plm_peak_hold.sv ----
/*
 * Peak magnitude tracker for one window of signed pcm samples.
 * Assumes the caller strobes i_update once per frame and raises
 * i_start on the first frame of each window.
 */
`timescale 1ns/100ps
`default_nettype none

module plm_peak_hold #(
    parameter int SAMPLE_W = 16
) (
    input  wire logic                i_sys_clk,  // system clock
    input  wire logic                i_rst_n,    // sync reset, active low
    input  wire logic                i_clk_en,   // freezes state when low
    input  wire logic                i_update,   // one frame sample taken
    input  wire logic                i_start,    // first frame of window
    input  wire logic [SAMPLE_W-1:0] i_sample,   // signed pcm sample
    output logic      [SAMPLE_W-1:0] o_merged    // peak including i_sample
);

    if (SAMPLE_W < 2) begin : g_bad_width
        $error("plm_peak_hold: SAMPLE_W must be at least 2");
    end

    logic [SAMPLE_W-1:0] peak;
    logic [SAMPLE_W-1:0] next_peak;
    logic [SAMPLE_W-1:0] magnitude;

    // ------------------------------------------------------------------
    // magnitude and merge
    // ------------------------------------------------------------------
    always_comb begin
        if (i_sample[SAMPLE_W-1]) begin
            magnitude = SAMPLE_W'(~i_sample + 1'b1);
        end else begin
            magnitude = i_sample;
        end
        if (i_start || (magnitude > peak)) begin
            o_merged = magnitude;
        end else begin
            o_merged = peak;
        end
        next_peak = peak;
        if (i_update) begin
            next_peak = o_merged;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            peak <= '0;
        end else if (i_clk_en) begin
            peak <= next_peak;
        end
    end

endmodule

`default_nettype wire

// ---- plm_level_meter.sv ----
/*
 * PCM level meter: window count, control and result registers behind a
 * byte-wide command port, frame-counted peak measurement of one channel.
 * Assumes i_frame_sync is an asynchronous 8 kHz pin, and i_pcm_data holds
 * the current signed linear sample of each channel on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module plm_level_meter #(
    parameter int SAMPLE_W = 16,
    parameter int CHANNELS = 4
) (
    input  wire logic                         i_sys_clk,   // 40 MHz clock
    input  wire logic                         i_rst_n,     // sync, low
    input  wire logic                         i_clk_en,    // freeze when low
    input  wire logic                         i_cmd_valid, // command strobe
    input  wire logic [7:0]                   i_cmd_byte,  // r/w and addr
    input  wire logic [7:0]                   i_cmd_wdata, // write data
    input  wire logic                         i_frame_sync,// 8 kHz pin
    input  wire logic [CHANNELS*SAMPLE_W-1:0] i_pcm_data,  // all channels
    output logic      [7:0]                   o_rd_data,   // read data
    output logic                              o_rd_valid,  // read pulse
    output logic                              o_res_valid, // result pulse
    output logic                              o_busy       // window open
);

    // result and read path are hard-wired for four 16-bit channels
    if (CHANNELS != 4 || SAMPLE_W != 16) begin : g_bad_shape
        $error("plm_level_meter: needs 4 channels of 16-bit samples");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]                cnt_lo;
    logic [7:0]                ctl;
    logic [15:0]               result;
    logic [10:0]               frame_cnt;
    logic [2:0]                sync_q;
    plm_pkg::plm_state_t       state;
    logic [7:0]                next_cnt_lo;
    logic [7:0]                next_ctl;
    logic [15:0]               next_result;
    logic [10:0]               next_frame_cnt;
    logic [7:0]                next_rd_data;
    logic                      next_rd_valid;
    logic                      next_res_valid;
    plm_pkg::plm_state_t       next_state;

    logic                      wr_en;
    logic                      rd_en;
    logic [6:0]                addr;
    logic                      frame_tick;
    logic [10:0]               window;
    logic [1:0]                chan;
    logic [SAMPLE_W-1:0]       sample;
    logic [SAMPLE_W-1:0]       merged;
    logic                      win_start;
    logic                      tick_meas;
    logic [10:0]               cnt_inc;
    logic                      done;

    assign wr_en      = i_cmd_valid && i_cmd_byte[plm_pkg::CMD_WR_BIT];
    assign rd_en      = i_cmd_valid && !i_cmd_byte[plm_pkg::CMD_WR_BIT];
    assign addr       = i_cmd_byte[plm_pkg::ADDR_W-1:0];
    // frame edge seen only on the second and third stages
    assign frame_tick = sync_q[1] && !sync_q[2];
    assign window     = {ctl[plm_pkg::CTL_CNT_MSB:0], cnt_lo};
    assign chan       = ctl[plm_pkg::CTL_CS_LSB +: plm_pkg::CTL_CS_W];
    assign sample     = i_pcm_data[chan*SAMPLE_W +: SAMPLE_W];
    assign tick_meas  = (state == plm_pkg::PLM_MEASURE) && frame_tick
                        && ctl[plm_pkg::CTL_EN_BIT];
    assign win_start  = (frame_cnt == 11'h000);
    assign cnt_inc    = frame_cnt + 11'h001;
    assign done       = tick_meas && (cnt_inc >= window);

    plm_peak_hold #(
        .SAMPLE_W (SAMPLE_W)
    ) plm_peak_hold_i (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_clk_en  (i_clk_en),
        .i_update  (tick_meas),
        .i_start   (win_start),
        .i_sample  (sample),
        .o_merged  (merged)
    );

    // ------------------------------------------------------------------
    // register file next values
    // ------------------------------------------------------------------
    always_comb begin
        next_cnt_lo    = cnt_lo;
        next_ctl       = ctl;
        next_rd_data   = 8'h00;
        next_rd_valid  = rd_en;
        if (done && ctl[plm_pkg::CTL_ONCE_BIT]) begin
            next_ctl[plm_pkg::CTL_EN_BIT] = 1'b0;
        end
        if (wr_en) begin
            case (addr)
                plm_pkg::ADDR_CNT_LO: next_cnt_lo = i_cmd_wdata;
                plm_pkg::ADDR_CTL: begin
                    next_ctl = i_cmd_wdata;
                    next_ctl[plm_pkg::CTL_RSVD_BIT] = 1'b0;
                end
                default: next_ctl = next_ctl;
            endcase
        end
        if (rd_en) begin
            case (addr)
                plm_pkg::ADDR_CNT_LO: next_rd_data = cnt_lo;
                plm_pkg::ADDR_CTL:    next_rd_data = ctl;
                plm_pkg::ADDR_RES_LO: next_rd_data = result[7:0];
                plm_pkg::ADDR_RES_HI: next_rd_data = result[15:8];
                default:              next_rd_data = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // measurement sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_frame_cnt = frame_cnt;
        next_result    = result;
        next_res_valid = 1'b0;
        case (state)
            plm_pkg::PLM_IDLE: begin
                next_frame_cnt = 11'h000;
                if (ctl[plm_pkg::CTL_EN_BIT]) begin
                    next_state = plm_pkg::PLM_MEASURE;
                end
            end
            plm_pkg::PLM_MEASURE: begin
                if (!ctl[plm_pkg::CTL_EN_BIT]) begin
                    next_state     = plm_pkg::PLM_IDLE;
                    next_frame_cnt = 11'h000;
                end else if (done) begin
                    next_res_valid = 1'b1;
                    next_frame_cnt = 11'h000;
                    if (window == plm_pkg::WINDOW_NONE) begin
                        next_result = sample;
                    end else begin
                        next_result = merged;
                    end
                    if (ctl[plm_pkg::CTL_ONCE_BIT]) begin
                        next_state = plm_pkg::PLM_IDLE;
                    end
                end else if (tick_meas) begin
                    next_frame_cnt = cnt_inc;
                end
            end
            default: begin
                next_state     = plm_pkg::PLM_IDLE;
                next_frame_cnt = 11'h000;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnt_lo      <= plm_pkg::RST_CNT_LO;
            ctl         <= plm_pkg::RST_CTL;
            result      <= plm_pkg::RST_RESULT;
            frame_cnt   <= 11'h000;
            sync_q      <= 3'h0;
            state       <= plm_pkg::PLM_IDLE;
            o_rd_data   <= 8'h00;
            o_rd_valid  <= 1'b0;
            o_res_valid <= 1'b0;
            o_busy      <= 1'b0;
        end else if (i_clk_en) begin
            cnt_lo      <= next_cnt_lo;
            ctl         <= next_ctl;
            result      <= next_result;
            frame_cnt   <= next_frame_cnt;
            sync_q      <= {sync_q[1:0], i_frame_sync};
            state       <= next_state;
            o_rd_data   <= next_rd_data;
            o_rd_valid  <= next_rd_valid;
            o_res_valid <= next_res_valid;
            o_busy      <= (next_state == plm_pkg::PLM_MEASURE);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_CNT_LO_READ: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && rd_en && addr == plm_pkg::ADDR_CNT_LO)
        |=> (o_rd_valid && o_rd_data == $past(cnt_lo)))
        else $error("count-low read mismatch");

    AST_WINDOW_BUILD: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && wr_en && addr == plm_pkg::ADDR_CTL)
        |=> (window[10:8] == $past(i_cmd_wdata[2:0])))
        else $error("window high bits not taken from control");

    AST_STEP_ON_FRAME: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        ($changed(frame_cnt) && frame_cnt != 11'h000)
        |-> ($past(frame_tick) && frame_cnt == $past(frame_cnt) + 11'h001))
        else $error("frame count moved without a frame");

    AST_TRANSPARENT: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && tick_meas && window == plm_pkg::WINDOW_NONE)
        |=> (o_res_valid && result == $past(sample)))
        else $error("zero window did not copy sample");

    AST_WINDOW_LEN: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && tick_meas && cnt_inc < window) |=> !o_res_valid)
        else $error("result before window closed");

    AST_RES_LO_NO_WRITE: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && wr_en && addr == plm_pkg::ADDR_RES_LO && !done)
        |=> $stable(result))
        else $error("write changed result");

    AST_RES_HI_READ: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && rd_en && addr == plm_pkg::ADDR_RES_HI)
        |=> (o_rd_data == $past(result[15:8])))
        else $error("result high read mismatch");

    AST_ONCE_STOPS: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && done && ctl[plm_pkg::CTL_ONCE_BIT] && !wr_en)
        |=> (!ctl[plm_pkg::CTL_EN_BIT] && state == plm_pkg::PLM_IDLE))
        else $error("single shot kept running");

    AST_DISABLE_IDLE: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && !ctl[plm_pkg::CTL_EN_BIT]) |=> !o_busy)
        else $error("meter busy while disabled");

endmodule

`default_nettype wire

// ---- plm_host_model.sv ----
/*
 * Host side of the level meter command port: byte writes and reads.
 * Assumes one clock shared with the meter and a one-cycle read answer.
 */
`timescale 1ns/100ps
`default_nettype none

module plm_host_model (
    input  wire logic       i_sys_clk,   // system clock
    input  wire logic [7:0] i_rd_data,   // read answer data
    input  wire logic       i_rd_valid,  // read answer pulse
    output logic            o_cmd_valid, // command strobe
    output logic      [7:0] o_cmd_byte,  // r/w and address
    output logic      [7:0] o_cmd_wdata  // write data
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_byte  = 8'h00;
        o_cmd_wdata = 8'h00;
    end

    // released lines show the inverse, never the last value
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_byte  <= {1'b1, a};
        o_cmd_wdata <= d;
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_byte  <= ~{1'b1, a};
        o_cmd_wdata <= ~d;
    endtask

    // answer is {valid, data} seen in the cycle after the taken edge
    task automatic rd(input logic [6:0] a, output logic [8:0] q);
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_byte  <= {1'b0, a};
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_byte  <= ~{1'b0, a};
        @(posedge i_sys_clk);
        q = {i_rd_valid, i_rd_data};
    endtask
endmodule

`default_nettype wire

// ---- plm_level_meter_bench.sv ----
/*
 * Self-checking bench of the pcm level meter: registers, transparent mode,
 * windows of several lengths, abort and single shot.
 * Assumes the frame pin may run faster than 8 kHz, edges alone count.
 */
`timescale 1ns/100ps
`default_nettype none

module plm_level_meter_bench;
    logic        i_sys_clk;
    logic        i_rst_n;
    logic        clk_en;
    logic        cmd_valid;
    logic [7:0]  cmd_byte;
    logic [7:0]  cmd_wdata;
    logic        i_frame_sync;
    logic [63:0] i_pcm_data;
    logic [7:0]  o_rd_data;
    logic        o_rd_valid;
    logic        o_res_valid;
    logic        o_busy;
    int          bad_count;
    int          num_checks;
    int          res_count;

    plm_level_meter plm_level_meter_i (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_clk_en    (clk_en),
        .i_cmd_valid (cmd_valid),
        .i_cmd_byte  (cmd_byte),
        .i_cmd_wdata (cmd_wdata),
        .i_frame_sync(i_frame_sync),
        .i_pcm_data  (i_pcm_data),
        .o_rd_data   (o_rd_data),
        .o_rd_valid  (o_rd_valid),
        .o_res_valid (o_res_valid),
        .o_busy      (o_busy)
    );

    plm_host_model plm_host_model_i (
        .i_sys_clk  (i_sys_clk),
        .i_rd_data  (o_rd_data),
        .i_rd_valid (o_rd_valid),
        .o_cmd_valid(cmd_valid),
        .o_cmd_byte (cmd_byte),
        .o_cmd_wdata(cmd_wdata)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        if (o_res_valid === 1'b1) res_count++;
    end

    // ------------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------------
    task automatic check(input string n, input logic [15:0] s,
                         input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rd_chk(input string n, input logic [6:0] a,
                          input logic [7:0] e);
        logic [8:0] q;
        plm_host_model_i.rd(a, q);
        check(n, {7'h00, q}, {8'h01, e});
    endtask

    // other channels carry a large sample so a wrong channel shows
    task automatic frame(input logic [15:0] s, input logic [1:0] ch);
        logic [63:0] d;
        d            = {4{16'h7123}};
        d[ch*16+:16] = s;
        @(posedge i_sys_clk);
        i_pcm_data          <= d;
        i_frame_sync        <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        i_frame_sync        <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd_chk("cnt_lo rst", plm_pkg::ADDR_CNT_LO, 8'h00);
        rd_chk("ctl rst", plm_pkg::ADDR_CTL, 8'h00);
        rd_chk("res_lo rst", plm_pkg::ADDR_RES_LO, 8'h00);
        rd_chk("res_hi rst", plm_pkg::ADDR_RES_HI, 8'h00);
        plm_host_model_i.wr(plm_pkg::ADDR_CNT_LO, 8'hA5);
        plm_host_model_i.wr(plm_pkg::ADDR_CTL, 8'hBF);
        rd_chk("cnt_lo rw", plm_pkg::ADDR_CNT_LO, 8'hA5);
        rd_chk("ctl rw", plm_pkg::ADDR_CTL, 8'hB7);
        plm_host_model_i.wr(plm_pkg::ADDR_RES_LO, 8'hFF);
        plm_host_model_i.wr(plm_pkg::ADDR_RES_HI, 8'hFF);
        rd_chk("res_lo ro", plm_pkg::ADDR_RES_LO, 8'h00);
        rd_chk("res_hi ro", plm_pkg::ADDR_RES_HI, 8'h00);
        rd_chk("unmapped", 7'h45, 8'h00);
    endtask

    task automatic t_transparent;
        for (int c = 0; c < 4; c++) begin
            plm_host_model_i.wr(plm_pkg::ADDR_CNT_LO, 8'h00);
            plm_host_model_i.wr(plm_pkg::ADDR_CTL, {2'b01, 2'(c), 4'h0});
            res_count = 0;
            frame(16'h8000, 2'(c));
            frame(16'h80F0 + 16'(c), 2'(c));
            check("raw count", 16'(res_count), 16'd2);
            rd_chk("raw lo", plm_pkg::ADDR_RES_LO, 8'hF0 + 8'(c));
            rd_chk("raw hi", plm_pkg::ADDR_RES_HI, 8'h80);
        end
        plm_host_model_i.wr(plm_pkg::ADDR_CTL, 8'h00);
    endtask

    // peak is 0x0123 from frame two unless the window count is larger
    task automatic t_window(input logic [10:0] n, input logic [1:0] ch,
                            input logic once);
        logic [15:0] pk;
        pk = (n < 11'd2) ? 16'h0001 :
             (n > 11'h123) ? {5'h00, n} : 16'h0123;
        plm_host_model_i.wr(plm_pkg::ADDR_CNT_LO, n[7:0]);
        plm_host_model_i.wr(plm_pkg::ADDR_CTL, {once, 1'b1, ch, 1'b0, n[10:8]});
        res_count = 0;
        for (int k = 1; k <= int'(n); k++) begin
            frame((k == 2) ? 16'hFEDD : 16'(k), ch);
            if (k == int'(n) - 1) check("early", 16'(res_count), 16'd0);
        end
        check("window done", 16'(res_count), 16'd1);
        rd_chk("peak lo", plm_pkg::ADDR_RES_LO, pk[7:0]);
        rd_chk("peak hi", plm_pkg::ADDR_RES_HI, pk[15:8]);
        if (once) begin
            rd_chk("once ctl", plm_pkg::ADDR_CTL, {2'b10, ch, 1'b0, n[10:8]});
            check("once busy", {15'h0, o_busy}, 16'h0000);
            frame(16'h0001, ch);
            check("once stop", 16'(res_count), 16'd1);
        end else begin
            plm_host_model_i.wr(plm_pkg::ADDR_CTL, 8'h00);
        end
    endtask

    task automatic t_abort;
        plm_host_model_i.wr(plm_pkg::ADDR_CNT_LO, 8'h03);
        plm_host_model_i.wr(plm_pkg::ADDR_CTL, 8'h40);
        repeat (2) @(posedge i_sys_clk);
        check("busy on", {15'h0, o_busy}, 16'h0001);
        res_count = 0;
        frame(16'h0400, 2'd0);
        plm_host_model_i.wr(plm_pkg::ADDR_CTL, 8'h00);
        repeat (3) frame(16'h0400, 2'd0);
        check("abort count", 16'(res_count), 16'd0);
        check("abort busy", {15'h0, o_busy}, 16'h0000);
        rd_chk("abort lo", plm_pkg::ADDR_RES_LO, 8'h23);
    endtask

    // a write while frozen is lost; reset acts even while frozen
    task automatic t_freeze;
        plm_host_model_i.wr(plm_pkg::ADDR_CTL, 8'h05);
        @(posedge i_sys_clk);
        clk_en <= 1'b0;
        plm_host_model_i.wr(plm_pkg::ADDR_CNT_LO, 8'h5A);
        @(posedge i_sys_clk);
        clk_en <= 1'b1;
        rd_chk("frozen wr", plm_pkg::ADDR_CNT_LO, 8'h03);
        rd_chk("ctl before rst", plm_pkg::ADDR_CTL, 8'h05);
        @(posedge i_sys_clk);
        clk_en  <= 1'b0;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        clk_en  <= 1'b1;
        rd_chk("rst cnt_lo", plm_pkg::ADDR_CNT_LO, 8'h00);
        rd_chk("rst ctl", plm_pkg::ADDR_CTL, 8'h00);
        rd_chk("rst res_lo", plm_pkg::ADDR_RES_LO, 8'h00);
        rd_chk("rst res_hi", plm_pkg::ADDR_RES_HI, 8'h00);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge i_sys_clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        bad_count    = 0;
        num_checks   = 0;
        res_count    = 0;
        clk_en       = 1'b1;
        i_rst_n      = 1'b0;
        i_frame_sync = 1'b0;
        i_pcm_data   = 64'h0000_0000_0000_0000;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_transparent();
        t_window(11'd3, 2'd0, 1'b0);
        t_abort();
        t_freeze();
        t_window(11'h100, 2'd2, 1'b0);
        t_window(11'd2, 2'd1, 1'b1);
        t_window(11'h7FF, 2'd3, 1'b0);
        report_and_stop();
    end
endmodule

`default_nettype wire
